// [logic/pci_dev_end.sv]
// Purpose: device end of the bus: dma burst initiator and cpu target
// Assumes: one bus clock; arbitration by request and grant
// Notes:   no target stop, retry or abort; parity is generated only
`timescale 1ns/1ps

module pci_dev_end
  import pci_link_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  pci_link_if.dev          bus,
  input  wire logic        i_demux_mode,
  input  wire logic        i_dma_start,
  input  wire logic        i_dma_write,
  input  wire logic        i_dma_fb2b,
  input  wire logic [31:0] i_dma_addr,
  input  wire logic [7:0]  i_dma_len,
  input  wire logic [31:0] i_dma_wdata,
  input  wire logic [3:0]  i_dma_be,
  input  wire logic [31:0] i_tgt_rdata,
  output logic             o_dma_busy,
  output logic             o_dma_done,
  output logic             o_dma_wnext,
  output logic             o_dma_rvalid,
  output logic [31:0]      o_dma_rdata,
  output logic             o_tgt_wr,
  output logic             o_tgt_rd,
  output logic [31:0]      o_tgt_addr,
  output logic [31:0]      o_tgt_wdata,
  output logic [3:0]       o_tgt_be,
  output space_type        o_tgt_space
);

  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_END}
    mst_state_type;
  typedef enum logic [1:0] {T_IDLE, T_WR, T_RD, T_END} tgt_state_type;

  typedef struct packed {
    mst_state_type mst;
    tgt_state_type tgt;
    logic          req_n;
    logic          mst_oe;
    logic          frame_n;
    logic          irdy_n;
    logic [3:0]    cbe;
    logic          ad_oe;
    logic [31:0]   ad;
    logic          tgt_oe;
    logic          devsel_n;
    logic          trdy_n;
    logic          par_oe;
    logic          par;
    logic          frame_prev;
    logic [31:0]   m_addr;
    logic [7:0]    m_left;
    logic          m_write;
    logic          m_chain;
    logic [3:0]    t_wait;
    logic [31:0]   t_addr;
    space_type     t_space;
    logic          dma_busy;
    logic          dma_done;
    logic          dma_wnext;
    logic          dma_rvalid;
    logic [31:0]   dma_rdata;
    logic          tgt_wr;
    logic          tgt_rd;
    logic [31:0]   tgt_addr;
    logic [31:0]   tgt_wdata;
    logic [3:0]    tgt_be;
  } state_type;

  localparam state_type STATE_RST = '{
    mst: M_IDLE, tgt: T_IDLE, t_space: SP_CFG, req_n: 1'b1,
    frame_n: 1'b1, irdy_n: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1,
    cbe: BE_NONE, frame_prev: 1'b1, default: '0};

  state_type q, d;
  logic      xfer;
  logic      addr_phase;
  logic      cfg_hit;
  logic      mem_hit;
  space_type hit_space;

  // a word moves only on a clock with both ready lines low
  assign xfer = !bus.irdy_n && !bus.trdy_n;
  // first clock of frame low, not our own address phase
  assign addr_phase = !bus.frame_n && q.frame_prev && !q.mst_oe;
  assign cfg_hit = (bus.cbe == CMD_CFG_RD) || (bus.cbe == CMD_CFG_WR);
  assign mem_hit = ((bus.cbe == CMD_MEM_RD) || (bus.cbe == CMD_MEM_WR))
                && (bus.ad[TGT_WIN_MSB:TGT_WIN_LSB] == TGT_WIN_BASE);
  assign hit_space = cfg_hit ? SP_CFG
                   : (bus.ad[LBB_SEL_BIT] ? SP_LBB : SP_REG);

  // next state of both roles and the parity line
  always_comb begin
    d = q;
    d.dma_done   = 1'b0;
    d.dma_wnext  = 1'b0;
    d.dma_rvalid = 1'b0;
    d.tgt_wr     = 1'b0;
    d.tgt_rd     = 1'b0;
    d.frame_prev = bus.frame_n;
    // parity trails its phase by one clock; demux mode pins it low
    d.par_oe = i_demux_mode | q.ad_oe;
    d.par    = i_demux_mode ? 1'b0 : even_par(q.ad, bus.cbe);

    // initiator role: dma bursts to host memory
    case (q.mst)
      M_IDLE: begin
        if (i_dma_start) begin
          d.m_addr   = i_dma_addr;
          d.m_left   = i_dma_len;
          d.m_write  = i_dma_write;
          d.m_chain  = 1'b0;
          d.req_n    = 1'b0;
          d.dma_busy = 1'b1;
          d.mst      = M_REQ;
        end
      end
      M_REQ: begin
        if (!bus.host_gnt_n && bus.frame_n && bus.irdy_n
            && (q.tgt == T_IDLE)) begin
          d.req_n   = 1'b1;
          d.mst_oe  = 1'b1;
          d.frame_n = 1'b0;
          d.ad_oe   = 1'b1;
          d.ad      = q.m_addr;
          d.cbe     = q.m_write ? CMD_MEM_WR : CMD_MEM_RD;
          d.mst     = M_ADDR;
        end
      end
      M_ADDR: begin
        // reads release the data lines for the turnaround clock
        d.ad_oe = q.m_write;
        if (q.m_write) begin
          d.ad        = i_dma_wdata;
          d.dma_wnext = 1'b1;
        end
        if (q.m_chain) begin
          d.irdy_n = 1'b1;
          d.cbe    = BE_NONE;
        end else begin
          d.irdy_n  = 1'b0;
          d.cbe     = i_dma_be;
          d.frame_n = (q.m_left == LEN_ONE);
        end
        d.m_chain = 1'b0;
        d.mst     = M_DATA;
      end
      M_DATA: begin
        if (q.irdy_n) begin
          // end of the single inserted wait of a chained burst
          d.irdy_n  = 1'b0;
          d.cbe     = i_dma_be;
          d.frame_n = (q.m_left == LEN_ONE);
        end else if (xfer) begin
          if (!q.m_write) begin
            d.dma_rdata  = bus.ad;
            d.dma_rvalid = 1'b1;
          end
          d.m_left = q.m_left - LEN_ONE;
          if (q.frame_n) begin
            // last phase done
            d.dma_done = 1'b1;
            d.irdy_n   = 1'b1;
            d.ad_oe    = 1'b0;
            d.cbe      = BE_NONE;
            d.mst      = M_END;
            // chaining only write after write: no data line handover
            if (i_dma_start && i_dma_fb2b && i_dma_write && q.m_write) begin
              d.m_left  = i_dma_len;
              d.m_chain = 1'b1;
              d.frame_n = 1'b0;
              d.ad_oe   = 1'b1;
              d.ad      = i_dma_addr;
              d.cbe     = CMD_MEM_WR;
              d.mst     = M_ADDR;
            end
          end else begin
            if (q.m_write) begin
              d.ad        = i_dma_wdata;
              d.dma_wnext = 1'b1;
            end
            d.cbe     = i_dma_be;
            d.frame_n = (q.m_left == LEN_TWO);
          end
        end
      end
      M_END: begin
        d.mst_oe   = 1'b0;
        d.dma_busy = 1'b0;
        d.mst      = M_IDLE;
      end
      default: d.mst = M_IDLE;
    endcase

    // target role: cpu access to config, registers, bridge
    case (q.tgt)
      T_IDLE: begin
        if (addr_phase && (cfg_hit || mem_hit)) begin
          d.t_space  = hit_space;
          d.tgt_addr = bus.ad;
          d.t_addr   = bus.ad;
          d.tgt_oe   = 1'b1;
          d.devsel_n = 1'b0;
          if (is_write(bus.cbe)) begin
            d.trdy_n = 1'b0;
            d.tgt    = T_WR;
          end else begin
            d.trdy_n = 1'b1;
            d.t_wait = read_waits(hit_space);
            d.tgt    = T_RD;
          end
        end
      end
      T_WR: begin
        if (xfer) begin
          d.tgt_wr    = 1'b1;
          d.tgt_addr  = q.t_addr;
          d.tgt_wdata = bus.ad;
          d.tgt_be    = bus.cbe;
          d.t_addr    = q.t_addr + ADDR_STEP;
          if (bus.frame_n) begin
            d.devsel_n = 1'b1;
            d.trdy_n   = 1'b1;
            d.tgt      = T_END;
          end
        end
      end
      T_RD: begin
        // drivers come on after turnaround and stay on
        d.ad_oe = 1'b1;
        if (q.trdy_n) begin
          if (q.t_wait == '0) begin
            d.ad     = i_tgt_rdata;
            d.trdy_n = 1'b0;
            d.tgt_rd = 1'b1;
          end else begin
            d.t_wait = q.t_wait - WAIT_ONE;
          end
        end else if (xfer) begin
          if (bus.frame_n) begin
            d.ad_oe    = 1'b0;
            d.devsel_n = 1'b1;
            d.trdy_n   = 1'b1;
            d.tgt      = T_END;
          end else begin
            // the reload clock itself counts as the first wait
            d.trdy_n   = 1'b1;
            d.t_wait   = read_waits(q.t_space) - WAIT_ONE;
            d.tgt_addr = q.tgt_addr + ADDR_STEP;
          end
        end
      end
      T_END: begin
        d.tgt_oe = 1'b0;
        d.tgt    = T_IDLE;
      end
      default: d.tgt = T_IDLE;
    endcase
  end

  // single bus clock for all sampling and driving
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // bus drive straight from the state register
  assign bus.dev_ad_o       = q.ad;
  assign bus.dev_ad_oe      = q.ad_oe;
  assign bus.dev_cbe_o      = q.cbe;
  assign bus.dev_mst_oe     = q.mst_oe;
  assign bus.dev_frame_n_o  = q.frame_n;
  assign bus.dev_irdy_n_o   = q.irdy_n;
  assign bus.dev_tgt_oe     = q.tgt_oe;
  assign bus.dev_devsel_n_o = q.devsel_n;
  assign bus.dev_trdy_n_o   = q.trdy_n;
  assign bus.dev_par_o      = q.par;
  assign bus.dev_par_oe     = q.par_oe;
  assign bus.dev_req_n      = q.req_n;

  // user side
  assign o_dma_busy   = q.dma_busy;
  assign o_dma_done   = q.dma_done;
  assign o_dma_wnext  = q.dma_wnext;
  assign o_dma_rvalid = q.dma_rvalid;
  assign o_dma_rdata  = q.dma_rdata;
  assign o_tgt_wr     = q.tgt_wr;
  assign o_tgt_rd     = q.tgt_rd;
  assign o_tgt_addr   = q.tgt_addr;
  assign o_tgt_wdata  = q.tgt_wdata;
  assign o_tgt_be     = q.tgt_be;
  assign o_tgt_space  = q.t_space;

endmodule

// [logic/pci_link_pkg.sv]
// Purpose: shared constants, types and helpers for both bus ends
// Assumes: 32-bit multiplexed address/data bus, active-low controls
// Notes:   byte enables and controls are active low, as on the wire
package pci_link_pkg;

  // bus commands carried on the byte-enable lines in the address phase
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam int         CMD_WR_BIT = 0;
  localparam logic [3:0] BE_NONE    = 4'hf;

  // target read wait states of the device per address space
  localparam logic [3:0] WAIT_CFG_RD = 4'h2;
  localparam logic [3:0] WAIT_REG_RD = 4'h3;
  localparam logic [3:0] WAIT_LBB_RD = 4'h3;
  localparam logic [3:0] WAIT_ONE    = 4'h1;

  // device target window: top address nibble, local bus bridge select
  localparam int         TGT_WIN_MSB  = 31;
  localparam int         TGT_WIN_LSB  = 28;
  localparam int         LBB_SEL_BIT  = 27;
  localparam logic [3:0] TGT_WIN_BASE = 4'hf;

  localparam logic [31:0] ADDR_STEP = 32'h4;
  localparam logic [7:0]  LEN_ONE   = 8'h1;
  localparam logic [7:0]  LEN_TWO   = 8'h2;

  // cycles the host waits for a device select before a master abort
  localparam logic [2:0] DEVSEL_TIMEOUT = 3'h5;
  localparam logic [2:0] TOUT_STEP      = 3'h1;

  typedef enum logic [1:0] {SP_CFG, SP_REG, SP_LBB} space_type;

  function automatic logic [3:0] read_waits(input space_type sp);
    case (sp)
      SP_CFG:  return WAIT_CFG_RD;
      SP_REG:  return WAIT_REG_RD;
      default: return WAIT_LBB_RD;
    endcase
  endfunction

  // even parity over data and byte enables of one phase
  function automatic logic even_par(input logic [31:0] ad,
                                    input logic [3:0]  cbe);
    return ^{ad, cbe};
  endfunction

  function automatic logic is_write(input logic [3:0] cmd);
    return cmd[CMD_WR_BIT];
  endfunction

endpackage

// [logic/pci_link_if.sv]
// Purpose: shared bus between the device end and the host end
// Assumes: each party gives value and enable; wire level is resolved here
// Notes:   undriven controls float high, undriven data reads as zero
`timescale 1ns/1ps
interface pci_link_if;

  // device drive
  logic [31:0] dev_ad_o;
  logic [3:0]  dev_cbe_o;
  logic        dev_ad_oe, dev_mst_oe, dev_frame_n_o, dev_irdy_n_o;
  logic        dev_tgt_oe, dev_devsel_n_o, dev_trdy_n_o;
  logic        dev_par_o, dev_par_oe, dev_req_n;
  // host drive
  logic [31:0] host_ad_o;
  logic [3:0]  host_cbe_o;
  logic        host_ad_oe, host_mst_oe, host_frame_n_o, host_irdy_n_o;
  logic        host_tgt_oe, host_devsel_n_o, host_trdy_n_o;
  logic        host_par_o, host_par_oe, host_gnt_n;
  localparam logic [3:0] BE_IDLE = 4'hf;
  // resolved wires
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic        frame_n, irdy_n, devsel_n, trdy_n, par;

  // the device wins a clash; a clash is itself a protocol fault
  assign ad = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 32'h0);
  assign cbe = dev_mst_oe ? dev_cbe_o
             : (host_mst_oe ? host_cbe_o : BE_IDLE);
  assign frame_n = dev_mst_oe ? dev_frame_n_o
                 : (host_mst_oe ? host_frame_n_o : 1'b1);
  assign irdy_n = dev_mst_oe ? dev_irdy_n_o
                : (host_mst_oe ? host_irdy_n_o : 1'b1);
  assign devsel_n = dev_tgt_oe ? dev_devsel_n_o
                  : (host_tgt_oe ? host_devsel_n_o : 1'b1);
  assign trdy_n = dev_tgt_oe ? dev_trdy_n_o
                : (host_tgt_oe ? host_trdy_n_o : 1'b1);
  assign par = dev_par_oe ? dev_par_o : (host_par_oe & host_par_o);

  modport dev (
    output dev_ad_o, dev_cbe_o, dev_ad_oe, dev_mst_oe, dev_frame_n_o,
    output dev_irdy_n_o, dev_tgt_oe, dev_devsel_n_o, dev_trdy_n_o,
    output dev_par_o, dev_par_oe, dev_req_n,
    input  ad, cbe, frame_n, irdy_n, devsel_n, trdy_n, par, host_gnt_n
  );

  modport host (
    output host_ad_o, host_cbe_o, host_ad_oe, host_mst_oe, host_frame_n_o,
    output host_irdy_n_o, host_tgt_oe, host_devsel_n_o, host_trdy_n_o,
    output host_par_o, host_par_oe, host_gnt_n,
    input  ad, cbe, frame_n, irdy_n, devsel_n, trdy_n, par, dev_req_n
  );

endinterface

// [logic/pci_host_end.sv]
// Purpose: host end: arbiter, cpu single-word initiator, memory target
// Assumes: cpu request is a level held until the done pulse
// Notes:   host memory target adds one wait between read words
`timescale 1ns/1ps
module pci_host_end
  import pci_link_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  pci_link_if.host         bus,
  input  wire logic        i_cpu_start,
  input  wire logic [3:0]  i_cpu_cmd,
  input  wire logic [31:0] i_cpu_addr,
  input  wire logic [31:0] i_cpu_wdata,
  input  wire logic [3:0]  i_cpu_be,
  input  wire logic        i_mem_wait,
  input  wire logic [31:0] i_mem_rdata,
  output logic             o_cpu_busy,
  output logic             o_cpu_done,
  output logic             o_cpu_abort,
  output logic [31:0]      o_cpu_rdata,
  output logic             o_mem_wr,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  output logic [3:0]       o_mem_be
);

  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_DATA, H_END} mst_state_type;
  typedef enum logic [1:0] {S_IDLE, S_WR, S_RD, S_END} tgt_state_type;

  typedef struct packed {
    mst_state_type mst;
    tgt_state_type tgt;
    logic          gnt_n;
    logic          gnt_prev;
    logic          mst_oe;
    logic          frame_n;
    logic          irdy_n;
    logic [3:0]    cbe;
    logic          ad_oe;
    logic [31:0]   ad;
    logic          tgt_oe;
    logic          devsel_n;
    logic          trdy_n;
    logic          par_oe;
    logic          par;
    logic          frame_prev;
    logic          c_write;
    logic [3:0]    c_be;
    logic [31:0]   c_wdata;
    logic [2:0]    tout;
    logic          cpu_busy;
    logic          cpu_done;
    logic          cpu_abort;
    logic [31:0]   cpu_rdata;
    logic [31:0]   run_addr;
    logic          mem_wr;
    logic [31:0]   mem_addr;
    logic [31:0]   mem_wdata;
    logic [3:0]    mem_be;
  } state_type;

  localparam state_type STATE_RST = '{
    mst: H_IDLE, tgt: S_IDLE, gnt_n: 1'b1, gnt_prev: 1'b1,
    frame_n: 1'b1, irdy_n: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1,
    cbe: BE_NONE, frame_prev: 1'b1, default: '0};

  state_type q, d;
  logic      xfer;

  assign xfer = !bus.irdy_n && !bus.trdy_n;

  always_comb begin
    d = q;
    d.cpu_done   = 1'b0;
    d.cpu_abort  = 1'b0;
    d.mem_wr     = 1'b0;
    d.frame_prev = bus.frame_n;
    d.par_oe     = q.ad_oe;
    d.par        = even_par(q.ad, bus.cbe);
    // grant only while no cpu access waits; gnt_prev guards the handover
    d.gnt_n    = !(!bus.dev_req_n && (q.mst == H_IDLE) && !i_cpu_start);
    d.gnt_prev = q.gnt_n;

    // cpu initiator, one word per transaction
    case (q.mst)
      H_IDLE: begin
        if (i_cpu_start && q.gnt_n && q.gnt_prev && bus.frame_n
            && bus.irdy_n && (q.tgt == S_IDLE)) begin
          d.mst_oe   = 1'b1;
          d.frame_n  = 1'b0;
          d.ad_oe    = 1'b1;
          d.ad       = i_cpu_addr;
          d.cbe      = i_cpu_cmd;
          d.c_write  = is_write(i_cpu_cmd);
          d.c_be     = i_cpu_be;
          d.c_wdata  = i_cpu_wdata;
          d.cpu_busy = 1'b1;
          d.mst      = H_ADDR;
        end
      end
      H_ADDR: begin
        // single word: last phase at once, frame off with irdy on
        d.irdy_n  = 1'b0;
        d.frame_n = 1'b1;
        d.cbe     = q.c_be;
        d.ad_oe   = q.c_write;
        d.ad      = q.c_wdata;
        d.tout    = '0;
        d.mst     = H_DATA;
      end
      H_DATA: begin
        if (xfer) begin
          if (!q.c_write) begin
            d.cpu_rdata = bus.ad;
          end
          d.cpu_done = 1'b1;
          d.irdy_n   = 1'b1;
          d.ad_oe    = 1'b0;
          d.cbe      = BE_NONE;
          d.mst      = H_END;
        end else if (bus.devsel_n) begin
          if (q.tout == DEVSEL_TIMEOUT) begin
            // nobody claimed the address: master abort
            d.cpu_abort = 1'b1;
            d.cpu_done  = 1'b1;
            d.irdy_n    = 1'b1;
            d.ad_oe     = 1'b0;
            d.cbe       = BE_NONE;
            d.mst       = H_END;
          end else begin
            d.tout = q.tout + TOUT_STEP;
          end
        end
      end
      H_END: begin
        d.mst_oe   = 1'b0;
        d.cpu_busy = 1'b0;
        d.mst      = H_IDLE;
      end
      default: d.mst = H_IDLE;
    endcase

    // host memory target for device bursts
    case (q.tgt)
      // a chained burst's address lands in our release clock
      S_IDLE, S_END: begin
        d.tgt_oe = 1'b0;
        d.tgt    = S_IDLE;
        if (!bus.frame_n && q.frame_prev && !q.mst_oe
            && ((bus.cbe == CMD_MEM_RD) || (bus.cbe == CMD_MEM_WR))) begin
          d.run_addr = bus.ad;
          d.mem_addr = bus.ad;
          d.tgt_oe   = 1'b1;
          d.devsel_n = 1'b0;
          if (is_write(bus.cbe)) begin
            d.trdy_n = i_mem_wait;
            d.tgt    = S_WR;
          end else begin
            d.trdy_n = 1'b1;
            d.tgt    = S_RD;
          end
        end
      end
      S_WR: begin
        if (xfer) begin
          d.mem_wr    = 1'b1;
          d.mem_addr  = q.run_addr;
          d.mem_wdata = bus.ad;
          d.mem_be    = bus.cbe;
          d.run_addr  = q.run_addr + ADDR_STEP;
        end
        if (xfer && bus.frame_n) begin
          d.devsel_n = 1'b1;
          d.trdy_n   = 1'b1;
          d.tgt      = S_END;
        end else begin
          d.trdy_n = i_mem_wait;
        end
      end
      S_RD: begin
        d.ad_oe = 1'b1;
        if (q.trdy_n) begin
          if (!i_mem_wait) begin
            d.ad     = i_mem_rdata;
            d.trdy_n = 1'b0;
          end
        end else if (xfer) begin
          if (bus.frame_n) begin
            d.ad_oe    = 1'b0;
            d.devsel_n = 1'b1;
            d.trdy_n   = 1'b1;
            d.tgt      = S_END;
          end else begin
            // next word is looked up during this wait
            d.trdy_n   = 1'b1;
            d.mem_addr = q.mem_addr + ADDR_STEP;
          end
        end
      end
      default: d.tgt = S_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.host_ad_o       = q.ad;
  assign bus.host_ad_oe      = q.ad_oe;
  assign bus.host_cbe_o      = q.cbe;
  assign bus.host_mst_oe     = q.mst_oe;
  assign bus.host_frame_n_o  = q.frame_n;
  assign bus.host_irdy_n_o   = q.irdy_n;
  assign bus.host_tgt_oe     = q.tgt_oe;
  assign bus.host_devsel_n_o = q.devsel_n;
  assign bus.host_trdy_n_o   = q.trdy_n;
  assign bus.host_par_o      = q.par;
  assign bus.host_par_oe     = q.par_oe;
  assign bus.host_gnt_n      = q.gnt_n;

  assign o_cpu_busy  = q.cpu_busy;
  assign o_cpu_done  = q.cpu_done;
  assign o_cpu_abort = q.cpu_abort;
  assign o_cpu_rdata = q.cpu_rdata;
  assign o_mem_wr    = q.mem_wr;
  assign o_mem_addr  = q.mem_addr;
  assign o_mem_wdata = q.mem_wdata;
  assign o_mem_be    = q.mem_be;

endmodule

// [tb/pci_link_chk.sv]
// Purpose: handshake assertions on the shared bus wires
// Assumes: host reads of device space use window addresses
// Notes:   parity check needs the device held in demux mode
`timescale 1ns/1ps
module pci_link_chk
  import pci_link_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        devsel_n,
  input wire logic        trdy_n,
  input wire logic        par,
  input wire logic        dev_ad_oe,
  input wire logic        host_ad_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ownership and turnaround of the shared lines
  chk_addr_owner: assert property (
    $fell(frame_n) |-> dev_ad_oe ^ host_ad_oe) else $error("addr owner");
  chk_read_turn: assert property (
    $fell(frame_n) && !cbe[CMD_WR_BIT] |=> !(dev_ad_oe | host_ad_oe))
    else $error("no turnaround");
  chk_trdy_sel: assert property (!trdy_n |-> !devsel_n)
    else $error("trdy before devsel");
  chk_read_hold: assert property (
    dev_ad_oe && !devsel_n && trdy_n |=> dev_ad_oe) else $error("ad drop");
  // frame and irdy relation; once irdy is on, a burst never drops it
  chk_frame_end: assert property ($rose(frame_n) |-> !irdy_n)
    else $error("frame end early");
  chk_burst_irdy: assert property (!irdy_n && !frame_n |=> !irdy_n)
    else $error("irdy wait");
  // exact target wait counts, turnaround cycle included
  chk_cfg_wait: assert property (
    $fell(frame_n) && cbe == CMD_CFG_RD |=> trdy_n [*3] ##1 !trdy_n)
    else $error("cfg waits");
  chk_win_wait: assert property (
    $fell(frame_n) && cbe == CMD_MEM_RD
    && ad[TGT_WIN_MSB:TGT_WIN_LSB] == TGT_WIN_BASE
    |=> trdy_n [*4] ##1 !trdy_n) else $error("reg waits");
  chk_par_low: assert property (!par) else $error("par high");
  // a chained burst idles irdy for exactly its first data clock
  chk_chain_wait: assert property (
    $fell(frame_n) && !$past(irdy_n) |=> irdy_n ##1 !irdy_n)
    else $error("chain wait");
  cover property ($fell(frame_n) && !$past(irdy_n));
  cover property ($fell(frame_n) && cbe == CMD_CFG_RD);
  cover property ($fell(frame_n) && cbe == CMD_MEM_WR);
  cover property (!irdy_n && !trdy_n && dev_ad_oe);
endmodule

// [tb/pci_master_target_handshake_bench.sv]
// Purpose: drives both bus ends against each other
// Assumes: demux mode on, so device parity stays low
// Notes:   wait counts are judged by the checker alongside
`timescale 1ns/1ps
module pci_master_target_handshake_bench;
  import pci_link_pkg::*;
  typedef struct packed {
    logic [3:0]  c;
    logic [31:0] a;
    logic [1:0]  s;
    logic        x;
  } row_type;
  // cpu accesses: command, address, space, abort expected
  row_type rows [6] = '{
    '{CMD_CFG_RD, 32'h00000010, 2'h0, 1'b0},
    '{CMD_CFG_WR, 32'h00000014, 2'h0, 1'b0},
    '{CMD_MEM_RD, 32'hf0000020, 2'h1, 1'b0},
    '{CMD_MEM_RD, 32'hf8000030, 2'h2, 1'b0},
    '{CMD_MEM_WR, 32'hf8000034, 2'h2, 1'b0},
    '{CMD_MEM_RD, 32'h10000000, 2'h0, 1'b1}};
  row_type r;
  logic i_core_clk = 0, i_reset_n = 0, i_demux_mode = 1, i_dma_fb2b = 0;
  logic i_dma_start = 0, i_dma_write = 0, i_cpu_start = 0, i_mem_wait = 0;
  logic [7:0] i_dma_len = 8'h4;
  logic [3:0] i_dma_be = 4'h3, i_cpu_be = 4'h5, i_cpu_cmd = 0;
  logic [3:0] o_tgt_be, o_mem_be;
  logic [31:0] i_dma_addr = 0, i_dma_wdata = 0, i_cpu_addr = 0, tw, mw, rd;
  logic [31:0] o_dma_rdata, o_tgt_addr, o_tgt_wdata, o_cpu_rdata, o_mem_addr;
  logic [31:0] o_mem_wdata, i_tgt_rdata, i_mem_rdata, i_cpu_wdata;
  logic o_dma_busy, o_dma_done, o_dma_wnext, o_dma_rvalid, o_tgt_wr, o_tgt_rd;
  logic o_cpu_busy, o_cpu_done, o_cpu_abort, o_mem_wr, ab, wt = 0;
  space_type o_tgt_space;
  int failures = 0, samples_checked = 0, mc = 0, rc = 0, tr = 0;
  pci_link_if i_pci_link_if ();
  pci_dev_end i_pci_dev_end (.bus(i_pci_link_if.dev), .*);
  pci_host_end i_pci_host_end (.bus(i_pci_link_if.host), .*);
  pci_link_chk i_pci_link_chk (.i_core_clk, .i_reset_n,
    .ad(i_pci_link_if.ad), .cbe(i_pci_link_if.cbe),
    .frame_n(i_pci_link_if.frame_n), .irdy_n(i_pci_link_if.irdy_n),
    .devsel_n(i_pci_link_if.devsel_n), .trdy_n(i_pci_link_if.trdy_n),
    .par(i_pci_link_if.par), .dev_ad_oe(i_pci_link_if.dev_ad_oe),
    .host_ad_oe(i_pci_link_if.host_ad_oe));
  always #12.5 i_core_clk = ~i_core_clk; // bus clock only, no serial
  // read data is the inverted address, so every word differs
  assign i_tgt_rdata = ~o_tgt_addr;
  assign i_mem_rdata = ~o_mem_addr;
  assign i_cpu_wdata = ~i_cpu_addr;
  // memory stalls every other cycle while enabled
  always @(negedge i_core_clk) begin
    i_mem_wait <= wt & ~i_mem_wait;
    if (o_dma_wnext) i_dma_wdata <= i_dma_wdata + 1;
  end
  always @(posedge i_core_clk) begin
    if (o_tgt_wr) tw <= o_tgt_wdata;
    if (o_mem_wr) mw <= o_mem_wdata;
    if (o_mem_wr) mc++;
    if (o_dma_rvalid) rd <= o_dma_rdata;
    if (o_dma_rvalid) rc++;
    if (o_tgt_rd) tr++;
  end
  task check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // start level is held until the done pulse is seen
  task cpu(input row_type q);
    i_cpu_cmd = q.c;
    i_cpu_addr = q.a;
    i_cpu_start = 1;
    repeat (40) begin
      @(negedge i_core_clk);
      if (o_cpu_done === 1'b1) break;
    end
    check("cpu done", o_cpu_done, 1'b1);
    ab = o_cpu_abort;
    i_cpu_start = 0;
    repeat (2) @(negedge i_core_clk);
  endtask
  task dma(input logic w);
    i_dma_write = w;
    i_dma_start = 1;
    repeat (80) begin
      @(negedge i_core_clk);
      // a chain needs start still high at the last word
      if (o_dma_busy === 1'b1 && !i_dma_fb2b) i_dma_start = 0;
      if (o_dma_done === 1'b1) break;
    end
    check("dma done", o_dma_done, 1'b1);
    i_dma_start = 0;
    @(negedge i_core_clk);
  endtask
  initial begin
    repeat (6) @(negedge i_core_clk);
    i_reset_n = 1;
    foreach (rows[i]) begin
      r = rows[i];
      cpu(r);
      check("abort", ab, r.x);
      check("busy", o_cpu_busy, 1'b0);
      if (!r.x) check("space", o_tgt_space, r.s);
      if (!r.x) check("data", r.c[0] ? tw : o_cpu_rdata, ~r.a);
    end
    check("tgt reads", tr, 3);
    check("tgt be", o_tgt_be, 4'h5);
    // stalled bursts: four words out, then four back
    wt = 1;
    i_dma_addr = 32'h100;
    i_dma_wdata = 32'ha0;
    dma(1);
    check("wr count", mc, 4);
    check("wr word", mw, 32'ha3);
    check("wr be", o_mem_be, 4'h3);
    dma(0);
    check("rd count", rc, 4);
    check("rd word", rd, ~32'h10c);
    // chained writes: two bursts of four with no idle clock
    i_dma_fb2b = 1;
    dma(1);
    @(negedge o_dma_busy);
    @(negedge i_core_clk);
    check("chain count", mc, 12);
    // second reset mid-run, then a read must still work
    i_reset_n = 0;
    @(negedge i_core_clk);
    i_reset_n = 1;
    cpu(rows[0]);
    check("after reset", o_cpu_rdata, ~rows[0].a);
    wrap_up;
  end
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule
